// ==== shared/pspc_consts.svh ====
/*
 Constants of the pulse start and polarity controller: register byte offsets,
 field positions, reset values and divider masks.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PSPC_CONSTS_SVH
`define PSPC_CONSTS_SVH

`define PSPC_NUM_CH           24
`define PSPC_NUM_CMP          12
`define PSPC_NUM_TG           3
`define PSPC_CMP_PER_TG       4

`define PSPC_OFS_CMP_BASE     8'h00
`define PSPC_OFS_CMP_END      8'h30
`define PSPC_OFS_DIRECT_LOW   8'h30
`define PSPC_OFS_DIRECT_HIGH  8'h34
`define PSPC_OFS_POL_LOW      8'h38
`define PSPC_OFS_POL_HIGH     8'h3c
`define PSPC_OFS_TRIG_SEL     8'h40
`define PSPC_OFS_EDGE_SEL     8'h44
`define PSPC_OFS_TG_CTRL0     8'h48
`define PSPC_OFS_TG_CTRL1     8'h4c
`define PSPC_OFS_TG_CTRL2     8'h50
`define PSPC_OFS_IRQ_STATUS   8'h54
`define PSPC_OFS_IRQ_MASK     8'h58

`define PSPC_TG_START_BIT     0
`define PSPC_TG_CSEL_LSB      1
`define PSPC_TG_RUN_BIT       3
`define PSPC_TG_STOP_LSB      4

`define PSPC_RST_CMP          8'h00
`define PSPC_RST_DIRECT       24'h000000
`define PSPC_RST_POL          24'h000000
`define PSPC_COUNT_LAST       8'hff

`define PSPC_DIV_MASK_2       6'h01
`define PSPC_DIV_MASK_8       6'h07
`define PSPC_DIV_MASK_32      6'h1f
`define PSPC_DIV_MASK_64      6'h3f

`define PSPC_RESP_OKAY        2'h0
`define PSPC_RESP_SLVERR      2'h2

`endif

// ==== shared/pspc_pkg.sv ====
/*
 Types of the pulse start and polarity controller.
 Assumes pspc_consts.svh on the include path.
*/
`include "pspc_consts.svh"

package pspc_pkg;

	typedef logic [`PSPC_NUM_CH-1:0] pspc_ch_t;

	typedef struct packed {
		logic [`PSPC_NUM_CMP-1:0][7:0] comp;
		pspc_ch_t                      direct;
		pspc_ch_t                      polarity;
		pspc_ch_t                      trig_sel;
		pspc_ch_t                      edge_sel;
		logic [`PSPC_NUM_TG-1:0][1:0]  clk_sel;
		logic [`PSPC_NUM_TG-1:0]       running;
		logic [`PSPC_NUM_TG-1:0][7:0]  count;
		logic [`PSPC_NUM_TG-1:0][5:0]  div;
		logic [`PSPC_NUM_CMP-1:0]      tg_start;
		pspc_ch_t                      irq_status;
		pspc_ch_t                      irq_mask;
		pspc_ch_t                      ch_start;
		logic                          aw_held;
		logic [7:0]                    awaddr;
		logic                          w_held;
		logic [31:0]                   wdata;
		logic [3:0]                    wstrb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
	} pspc_state_s;

	typedef struct packed {
		logic pin_level;
		logic width_swap;
		logic flag_set;
		logic presc_clk;
	} pspc_pol_s;

endpackage : pspc_pkg

// ==== core/pspc_chan_pol.sv ====
/*
 Polarity stage of one pulse channel: pin level, width swap, flag event
 selection and prescaler clock inversion.
 Assumes the channel reports its internal phase ends as one-cycle pulses.
*/
`timescale 1ns/10ps
`include "pspc_consts.svh"

module pspc_chan_pol (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic reverse,
	input  wire logic flag_edge_select,
	input  wire logic presc_link,
	input  wire logic raw_level,
	input  wire logic low_end,
	input  wire logic high_end,
	input  wire logic presc_clk_in,
	output logic      pin_level,
	output logic      width_swap,
	output logic      flag_set,
	output logic      presc_clk_out
);
	import pspc_pkg::*;

	pspc_pol_s st;
	pspc_pol_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.pin_level = raw_level ^ reverse;
		next_st.width_swap = reverse;
		// both ends or high end only
		// internal high is the pin's low when reversed
		next_st.flag_set = flag_edge_select ? high_end : (low_end | high_end);
		next_st.presc_clk = presc_clk_in ^ (reverse & presc_link);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign pin_level     = st.pin_level;
	assign width_swap    = st.width_swap;
	assign flag_set      = st.flag_set;
	assign presc_clk_out = st.presc_clk;

endmodule : pspc_chan_pol

// ==== core/pspc_top.sv ====
/*
 Pulse start and polarity controller: compare-started starts for 12 and direct
 starts for 24 pulse channels, output polarity, underflow flags and interrupt, AXI4-Lite.
 Assumes one clock, AXI4-Lite master with one write and one read at a time.
*/
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
// Operation
// - One 8-bit read/write compare value per timing start signal, reset zero.
// - Compare equal to up-counter asserts the tied channel's start signal.
// - Compare value zero never matches.
// - Direct start bit one starts channel, zero stops it; reset zero.
// - Bit n drives channel n; 16 bits low register, 8 bits high register.
// - One write changing several direct bits acts on all in one cycle.
// - Direct bit matters only when the channel selects direct start.
// - Reverse bit inverts output; reversed idle level is high.
// - Reverse bit swaps low-width and high-width reload meanings.
// - Reversed with high-end-only flag mode, flag sets at pin low end.
// - Reverse inverts prescaler clock fed to output side in linked modes.
// - Up-counter counts from zero, stops after 0xff, running status readable.
// - Writing zero to a stop bit negates its compare start; one ignored.
// - Flag mode clear: flag at both phase ends; set: high end only.
`timescale 1ns/10ps
`include "pspc_consts.svh"

module pspc_top (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire pspc_pkg::pspc_ch_t ch_raw_level,
	input  wire pspc_pkg::pspc_ch_t ch_low_end,
	input  wire pspc_pkg::pspc_ch_t ch_high_end,
	input  wire pspc_pkg::pspc_ch_t ch_presc_clk,
	input  wire pspc_pkg::pspc_ch_t ch_presc_link,
	output pspc_pkg::pspc_ch_t    ch_start,
	output pspc_pkg::pspc_ch_t    ch_pin_level,
	output pspc_pkg::pspc_ch_t    ch_width_swap,
	output pspc_pkg::pspc_ch_t    ch_presc_clk_out,
	output logic                  irq
);
	import pspc_pkg::*;

	pspc_state_s st;
	pspc_state_s next_st;
	pspc_ch_t    flag_set;

	// Compare index to channel: generator 0 feeds 0,2,4,6, 1 feeds 1,3,5,7, 2 feeds 16,18,20,22
	function automatic logic [4:0] cmp_to_ch(input int k);
		logic [4:0] base;
		base = (k / `PSPC_CMP_PER_TG == 0) ? 5'h00 :
		       (k / `PSPC_CMP_PER_TG == 1) ? 5'h01 : 5'h10;
		return 5'(base + 5'(2 * (k % `PSPC_CMP_PER_TG)));
	endfunction : cmp_to_ch

	function automatic logic [5:0] div_mask(input logic [1:0] sel);
		case (sel)
			2'h0:    return `PSPC_DIV_MASK_2;
			2'h1:    return `PSPC_DIV_MASK_8;
			2'h2:    return `PSPC_DIV_MASK_32;
			default: return `PSPC_DIV_MASK_64;
		endcase
	endfunction : div_mask

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
	                                           input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = new_v[8*b +: 8];
		return r;
	endfunction : merge_strb

	function automatic logic [31:0] tg_ctrl_read(input pspc_state_s s, input int t);
		logic [31:0] r;
		r = 32'h0;
		r[`PSPC_TG_CSEL_LSB +: 2]  = s.clk_sel[t];
		r[`PSPC_TG_RUN_BIT]        = s.running[t];
		// Stop bits always read as one
		r[`PSPC_TG_STOP_LSB +: 4]  = 4'hf;
		return r;
	endfunction : tg_ctrl_read

	always_comb
	begin
		logic [31:0] wv;
		logic        wr_ok;
		logic        rd_ok;
		logic [31:0] rv;
		int          t;
		wv      = 32'h0;
		wr_ok   = 1'b0;
		rd_ok   = 1'b0;
		rv      = 32'h0;
		t       = 0;
		next_st = st;

		for (int g = 0; g < `PSPC_NUM_TG; g++)
		begin
			if (st.running[g])
			begin
				next_st.div[g] = 6'(st.div[g] + 6'h01);
				if ((st.div[g] & div_mask(st.clk_sel[g])) == div_mask(st.clk_sel[g]))
				begin
					if (st.count[g] == `PSPC_COUNT_LAST)
						next_st.running[g] = 1'b0;
					else
						next_st.count[g] = 8'(st.count[g] + 8'h01);
				end
			end
		end

		for (int k = 0; k < `PSPC_NUM_CMP; k++)
		begin
			t = k / `PSPC_CMP_PER_TG;
			if (st.running[t] && st.comp[k] != `PSPC_RST_CMP && st.comp[k] == st.count[t])
				next_st.tg_start[k] = 1'b1;
		end

		// Write performed once address and data are both held
		if (st.aw_held && st.w_held && !st.bvalid)
		begin
			wr_ok = 1'b1;
			wv    = st.wdata;
			if (st.awaddr < `PSPC_OFS_CMP_END)
			begin
				if (st.wstrb[0])
					next_st.comp[st.awaddr[5:2]] = wv[7:0];
			end
			else
			begin
				case (st.awaddr)
					`PSPC_OFS_DIRECT_LOW:
						next_st.direct[15:0] = 16'(merge_strb({16'h0, st.direct[15:0]}, wv,
						                       st.wstrb));
					`PSPC_OFS_DIRECT_HIGH:
						next_st.direct[23:16] = 8'(merge_strb({24'h0, st.direct[23:16]}, wv,
						                        st.wstrb));
					`PSPC_OFS_POL_LOW:
						next_st.polarity[15:0] = 16'(merge_strb({16'h0, st.polarity[15:0]}, wv,
						                         st.wstrb));
					`PSPC_OFS_POL_HIGH:
						next_st.polarity[23:16] = 8'(merge_strb({24'h0, st.polarity[23:16]}, wv,
						                          st.wstrb));
					`PSPC_OFS_TRIG_SEL:
						next_st.trig_sel = 24'(merge_strb({8'h0, st.trig_sel}, wv, st.wstrb));
					`PSPC_OFS_EDGE_SEL:
						next_st.edge_sel = 24'(merge_strb({8'h0, st.edge_sel}, wv, st.wstrb));
					`PSPC_OFS_TG_CTRL0, `PSPC_OFS_TG_CTRL1, `PSPC_OFS_TG_CTRL2:
					begin
						t = (st.awaddr == `PSPC_OFS_TG_CTRL0) ? 0 :
						    (st.awaddr == `PSPC_OFS_TG_CTRL1) ? 1 : 2;
						if (st.wstrb[0])
						begin
							next_st.clk_sel[t] = wv[`PSPC_TG_CSEL_LSB +: 2];
							// Restart ignored while counting
							if (wv[`PSPC_TG_START_BIT] && !st.running[t])
							begin
								next_st.running[t] = 1'b1;
								next_st.count[t]   = 8'h00;
								next_st.div[t]     = 6'h00;
							end
							// stop bit zero negates, beats a match
							for (int j = 0; j < `PSPC_CMP_PER_TG; j++)
								if (!wv[`PSPC_TG_STOP_LSB + j])
									next_st.tg_start[t * `PSPC_CMP_PER_TG + j] = 1'b0;
						end
					end
					`PSPC_OFS_IRQ_STATUS:
						next_st.irq_status = st.irq_status &
						                     ~24'(merge_strb(32'h0, wv, st.wstrb));
					`PSPC_OFS_IRQ_MASK:
						next_st.irq_mask = 24'(merge_strb({8'h0, st.irq_mask}, wv, st.wstrb));
					default:
						wr_ok = 1'b0;
				endcase
			end
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = wr_ok ? `PSPC_RESP_OKAY : `PSPC_RESP_SLVERR;
		end

		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_held = 1'b1;
			next_st.awaddr  = {s_axi_awaddr[7:2], 2'h0};
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_held = 1'b1;
			next_st.wdata  = s_axi_wdata;
			next_st.wstrb  = s_axi_wstrb;
		end

		// Read decode
		if (s_axi_arvalid && s_axi_arready)
		begin
			rd_ok = 1'b1;
			if ({s_axi_araddr[7:2], 2'h0} < `PSPC_OFS_CMP_END)
				rv = {24'h0, st.comp[s_axi_araddr[5:2]]};
			else
			begin
				case ({s_axi_araddr[7:2], 2'h0})
					`PSPC_OFS_DIRECT_LOW:  rv = {16'h0, st.direct[15:0]};
					`PSPC_OFS_DIRECT_HIGH: rv = {24'h0, st.direct[23:16]};
					`PSPC_OFS_POL_LOW:     rv = {16'h0, st.polarity[15:0]};
					`PSPC_OFS_POL_HIGH:    rv = {24'h0, st.polarity[23:16]};
					`PSPC_OFS_TRIG_SEL:    rv = {8'h0, st.trig_sel};
					`PSPC_OFS_EDGE_SEL:    rv = {8'h0, st.edge_sel};
					`PSPC_OFS_TG_CTRL0:    rv = tg_ctrl_read(st, 0);
					`PSPC_OFS_TG_CTRL1:    rv = tg_ctrl_read(st, 1);
					`PSPC_OFS_TG_CTRL2:    rv = tg_ctrl_read(st, 2);
					`PSPC_OFS_IRQ_STATUS:  rv = {8'h0, st.irq_status};
					`PSPC_OFS_IRQ_MASK:    rv = {8'h0, st.irq_mask};
					default:               rd_ok = 1'b0;
				endcase
			end
			next_st.rvalid = 1'b1;
			next_st.rdata  = rv;
			next_st.rresp  = rd_ok ? `PSPC_RESP_OKAY : `PSPC_RESP_SLVERR;
		end
		else if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;

		// New events win over a clear in the same cycle
		next_st.irq_status = next_st.irq_status | flag_set;

		for (int n = 0; n < `PSPC_NUM_CH; n++)
		begin
			next_st.ch_start[n] = next_st.direct[n];
			if (next_st.trig_sel[n])
			begin
				next_st.ch_start[n] = 1'b0;
				for (int k = 0; k < `PSPC_NUM_CMP; k++)
					if (cmp_to_ch(k) == 5'(n) && next_st.tg_start[k])
						next_st.ch_start[n] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	for (genvar n = 0; n < `PSPC_NUM_CH; n++)
	begin : g_pol
		pspc_chan_pol u_pol (
			.sys_clk          (sys_clk),
			.rst_n            (rst_n),
			.reverse          (st.polarity[n]),
			.flag_edge_select (st.edge_sel[n]),
			.presc_link       (ch_presc_link[n]),
			.raw_level        (ch_raw_level[n]),
			.low_end          (ch_low_end[n]),
			.high_end         (ch_high_end[n]),
			.presc_clk_in     (ch_presc_clk[n]),
			.pin_level        (ch_pin_level[n]),
			.width_swap       (ch_width_swap[n]),
			.flag_set         (flag_set[n]),
			.presc_clk_out    (ch_presc_clk_out[n])
		);
	end

	// One transfer each way; no new address or data until response taken
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready  = !st.w_held && !st.bvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign ch_start      = st.ch_start;
	assign irq           = |(st.irq_status & st.irq_mask);

endmodule : pspc_top

// ==== sim/pspc_chan_model.sv ====
/*
 Behavioural pulse channels on the far side of the controller.
 Assumes start and width swap levels from the controller, one clock.
*/
`timescale 1ns/10ps
module pspc_chan_model (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire pspc_pkg::pspc_ch_t ch_start,
	input  wire pspc_pkg::pspc_ch_t ch_width_swap,
	output pspc_pkg::pspc_ch_t      ch_raw_level,
	output pspc_pkg::pspc_ch_t      ch_low_end,
	output pspc_pkg::pspc_ch_t      ch_high_end,
	output pspc_pkg::pspc_ch_t      ch_presc_clk
);
	import pspc_pkg::*;
	logic [2:0] cnt [$bits(pspc_ch_t)];
	// swapped widths: low 5, high 2
	always @(posedge sys_clk or negedge rst_n)
	begin
		ch_presc_clk <= rst_n ? ~ch_presc_clk : '0;
		for (int i = 0; i < $bits(pspc_ch_t); i++)
		begin
			ch_low_end[i]  <= 1'b0;
			ch_high_end[i] <= 1'b0;
			cnt[i]         <= cnt[i] + 3'h1;
			if (!rst_n || !ch_start[i])
			begin
				cnt[i]          <= 3'h0;
				ch_raw_level[i] <= 1'b0;
			end
			else if (cnt[i] == ((ch_raw_level[i] ^ ch_width_swap[i]) ? 3'h4 : 3'h1))
			begin
				cnt[i]          <= 3'h0;
				ch_low_end[i]   <= !ch_raw_level[i];
				ch_high_end[i]  <= ch_raw_level[i];
				ch_raw_level[i] <= !ch_raw_level[i];
			end
		end
	end
endmodule : pspc_chan_model

// ==== sim/pspc_top_asserts.sv ====
/*
 Port checker of the pulse start and polarity controller.
 Assumes binding onto pspc_top; one clock domain.
*/
`timescale 1ns/10ps
module pspc_top_asserts (
	input wire logic               sys_clk,
	input wire logic               rst_n,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire pspc_pkg::pspc_ch_t ch_raw_level,
	input wire pspc_pkg::pspc_ch_t ch_low_end,
	input wire pspc_pkg::pspc_ch_t ch_high_end,
	input wire pspc_pkg::pspc_ch_t ch_presc_clk,
	input wire pspc_pkg::pspc_ch_t ch_presc_link,
	input wire pspc_pkg::pspc_ch_t ch_start,
	input wire pspc_pkg::pspc_ch_t ch_pin_level,
	input wire pspc_pkg::pspc_ch_t ch_width_swap,
	input wire pspc_pkg::pspc_ch_t ch_presc_clk_out,
	input wire logic               irq
);
	import pspc_pkg::*;
	logic [2:0] bv_hist;
	logic       any_end;
	assign any_end = |(ch_low_end | ch_high_end);
	// Recent write responses; register effects lag them
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			bv_hist <= 3'h0;
		else
			bv_hist <= {bv_hist[1:0], s_axi_bvalid};
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	property p_pin;
		ch_pin_level == ($past(ch_raw_level) ^ ch_width_swap);
	endproperty
	a_pin: assert property (p_pin) else $error("pin level wrong");
	property p_presc;
		ch_presc_clk_out == ($past(ch_presc_clk) ^ (ch_width_swap & $past(ch_presc_link)));
	endproperty
	a_presc: assert property (p_presc) else $error("prescaler clock wrong");
	property p_swap;
		$changed(ch_width_swap) |-> s_axi_bvalid || (|bv_hist);
	endproperty
	a_swap: assert property (p_swap) else $error("swap moved alone");
	property p_start;
		|($past(ch_start) & ~ch_start) |-> s_axi_bvalid || (|bv_hist);
	endproperty
	a_start: assert property (p_start) else $error("start dropped alone");
	property p_irqr;
		$rose(irq) |-> s_axi_bvalid || $past(any_end, 2) || $past(any_end, 3);
	endproperty
	a_irqr: assert property (p_irqr) else $error("irq rose without cause");
	property p_irqf;
		$fell(irq) |-> s_axi_bvalid || (|bv_hist);
	endproperty
	a_irqf: assert property (p_irqf) else $error("irq fell without write");
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_bv;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bv: assert property (p_bv) else $error("response repeated");
endmodule : pspc_top_asserts
bind pspc_top pspc_top_asserts u_chk (.*);

// ==== sim/tb_pspc_top.sv ====
/*
 Self-checking bench of the pulse start and polarity controller.
 Assumes the far-side channel model and the bound checker.
*/
`timescale 1ns/10ps
module tb_pspc_top;
	import pspc_pkg::*;
	logic        sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	pspc_ch_t    ch_raw_level, ch_low_end, ch_high_end, ch_presc_clk, ch_presc_link;
	pspc_ch_t    ch_start, ch_pin_level, ch_width_swap, ch_presc_clk_out;
	int          error_cnt, cmp_count, cyc;
	logic [7:0]  rst_ofs [6] = '{8'h00, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
	pspc_top        uut (.*);
	pspc_chan_model u_far (.*);
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Generous ceiling; the counter run needs about 512 cycles
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Readies sampled at the falling edge, so the rising edge never races
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		do
		begin
			@(negedge sys_clk);
			aw = s_axi_awready;
			w  = s_axi_wready;
			b  = s_axi_bvalid;
			@(posedge sys_clk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		while (!b);
	endtask : axi_wr
	// Readies held high; no release and raise in one time step between transfers
	logic running;
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, rv;
		logic [31:0] d;
		logic [1:0]  r;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge sys_clk);
			ar = s_axi_arready;
			rv = s_axi_rvalid;
			d  = s_axi_rdata;
			r  = s_axi_rresp;
			@(posedge sys_clk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		while (!rv);
		if (ed !== 32'hffffffff)
			chk("rdata", ed, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
		running = d[3];
	endtask : rd_chk
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input pspc_ch_t st, input logic iq);
		axi_wr(a, d);
		@(negedge sys_clk);
		chk("ch_start", {8'h0, st}, {8'h0, ch_start});
		chk("irq", {31'h0, iq}, {31'h0, irq});
		@(posedge sys_clk);
	endtask : wr_chk
	// Run of channel 4, stretched by hold cycles; hold 0 ends only its first phase
	task automatic run_ch4(input logic [31:0] sel, input int hold);
		axi_wr(8'h44, sel);
		wr_chk(8'h30, 32'h10, 24'h10, 1'b0);
		repeat (hold) @(posedge sys_clk);
		axi_wr(8'h30, 32'h0);
		repeat (4) @(posedge sys_clk);
	endtask : run_ch4
	initial
	begin
		int n;
		rst_n         = 1'b0;
		s_axi_awaddr  = 8'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata   = 32'h0;
		s_axi_wstrb   = 4'hf;
		s_axi_wvalid  = 1'b0;
		s_axi_bready  = 1'b1;
		s_axi_araddr  = 8'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready  = 1'b1;
		ch_presc_link = 24'h000008;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		foreach (rst_ofs[i])
			rd_chk(rst_ofs[i], 32'h0, 2'h0);
		wr_chk(8'h30, 32'h8001, 24'h008001, 1'b0);
		wr_chk(8'h34, 32'h81, 24'h818001, 1'b0);
		wr_chk(8'h30, 32'h0, 24'h810000, 1'b0);
		wr_chk(8'h34, 32'h0, 24'h0, 1'b0);
		axi_wr(8'h40, 32'h105);
		wr_chk(8'h30, 32'h100, 24'h0, 1'b0);
		axi_wr(8'h00, 32'h3);
		axi_wr(8'h04, 32'h1a5);
		rd_chk(8'h04, 32'ha5, 2'h0);
		axi_wr(8'h04, 32'h0);
		axi_wr(8'h48, 32'hf1);
		rd_chk(8'h48, 32'hf8, 2'h0);
		n = 0;
		do
		begin
			rd_chk(8'h48, 32'hffffffff, 2'h0);
			n++;
		end
		while (running && n < 600);
		rd_chk(8'h48, 32'hf0, 2'h0);
		axi_wr(8'h50, 32'h6);
		rd_chk(8'h50, 32'hf6, 2'h0);
		wr_chk(8'h4c, 32'hf0, 24'h1, 1'b0);
		wr_chk(8'h48, 32'he0, 24'h0, 1'b0);
		axi_wr(8'h38, 32'h8);
		@(negedge sys_clk);
		chk("pin_level", 32'h8, {8'h0, ch_pin_level});
		chk("width_swap", 32'h8, {8'h0, ch_width_swap});
		@(posedge sys_clk);
		// Only byte lane 1 written
		s_axi_wstrb <= 4'h2;
		axi_wr(8'h38, 32'hffff);
		s_axi_wstrb <= 4'hf;
		rd_chk(8'h38, 32'hff08, 2'h0);
		axi_wr(8'h54, 32'hffffff);
		axi_wr(8'h58, 32'h10);
		run_ch4(32'h10, 0);
		rd_chk(8'h54, 32'h0, 2'h0);
		run_ch4(32'h0, 0);
		rd_chk(8'h54, 32'h10, 2'h0);
		wr_chk(8'h58, 32'h0, 24'h0, 1'b0);
		wr_chk(8'h58, 32'h10, 24'h0, 1'b1);
		wr_chk(8'h54, 32'h10, 24'h0, 1'b0);
		// Reversed, high end only: pin high phase ends first, no flag yet
		axi_wr(8'h38, 32'h10);
		run_ch4(32'h10, 2);
		rd_chk(8'h54, 32'h0, 2'h0);
		run_ch4(32'h10, 8);
		rd_chk(8'h54, 32'h10, 2'h0);
		rd_chk(8'h7c, 32'h0, 2'h2);
		tally_and_finish();
	end
endmodule : tb_pspc_top
